//--- core/dom_diag_mux.sv
// Diagnostic output multiplexer top
`timescale 1ns/100ps
module dom_diag_mux (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Configuration write
   input  wire logic       cfgWe,
   input  wire logic [7:0] diagConfigIn,
   input  wire logic [7:0] diagSelectIn,
   // Internal digital sources, indexed by channel
   input  wire logic [15:0] grpSupply,
   input  wire logic [15:0] grpTiming,
   input  wire logic [15:0] grpPower,
   input  wire logic [15:0] grpSensor,
   input  wire logic        factoryTestFlag,
   // Pins sampled for readback
   input  wire logic       errorTriggerPin,
   input  wire logic       chipSelectPin,
   input  wire logic       serialInPin,
   input  wire logic       serialClkPin,
   // Diagnostic pin and analog selector
   output logic            diagOutputPin,
   output logic            diagOutputOe,
   output logic [7:0]      analogSelect,
   output logic            analogActive,
   // Serial data output override
   output logic            serialOutForce,
   output logic            serialOutValue,
   output logic            serialOutKeepDriven,
   // Configuration readback
   output logic [7:0]      diagConfigReg,
   output logic [7:0]      diagSelectField
);
   // ****************************************
   // Configuration registers
   // ****************************************
   dom_cfg_if cfg ();
   logic [7:0] pinSync;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         diagConfigReg   <= dom_pkg::CFG_RST;
         diagSelectField <= dom_pkg::SEL_RST;
      end else if (cfgWe) begin
         diagConfigReg   <= diagConfigIn;
         diagSelectField <= diagSelectIn;
      end
   end

   assign cfg.enable = diagConfigReg[dom_pkg::CFG_EN_BIT];
   assign cfg.mode   = diagConfigReg[dom_pkg::MODE_HI:dom_pkg::MODE_LO];
   assign cfg.sel    = diagSelectField;
   assign cfg.level  = diagConfigReg[dom_pkg::LVL_BIT];

   // Pins come from outside the clock domain
   dom_sync #(.W(8)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .din      ({4'h0, serialClkPin, serialInPin, chipSelectPin, errorTriggerPin}),
      .dout     (pinSync)
   );

   // ****************************************
   // Digital channel decode
   // ****************************************
   function automatic logic pick(input logic [15:0] v, input logic [3:0] ch);
      pick = (ch == 4'h0) ? 1'b0 : v[ch];
   endfunction : pick

   logic digBit;
   logic [3:0] chn;
   assign chn = cfg.sel[dom_pkg::CHN_HI:dom_pkg::CHN_LO];

   // Pin readbacks use the synchronised copies, never the raw pins
   logic timingBit;
   always_comb begin
      case (chn)
         dom_pkg::CHN_ERRTRIG_A: timingBit = pinSync[0];
         dom_pkg::CHN_ERRTRIG_B: timingBit = pinSync[0];
         dom_pkg::CHN_CSEL:      timingBit = pinSync[1];
         dom_pkg::CHN_SDI:       timingBit = pinSync[2];
         dom_pkg::CHN_SCLK:      timingBit = pinSync[3];
         default:                timingBit = pick(grpTiming, chn);
      endcase
   end

   always_comb begin
      unique case (cfg.sel[dom_pkg::GRP_HI:dom_pkg::GRP_LO])
         dom_pkg::GRP_SUPPLY: digBit = pick(grpSupply, chn);
         dom_pkg::GRP_TIMING: digBit = timingBit;
         dom_pkg::GRP_POWER:  digBit = pick(grpPower, chn);
         // Reserved sensor channels read low
         dom_pkg::GRP_SENSOR: digBit = (chn > dom_pkg::CHN_SENSOR_LAST)
                                       ? 1'b0 : pick(grpSensor, chn);
         dom_pkg::GRP_FACTORY: digBit = (chn == 4'h1) & factoryTestFlag;
         default: digBit = 1'b0;
      endcase
   end

   logic iconBit;
   always_comb begin
      unique case (diagConfigReg[dom_pkg::ICON_HI:dom_pkg::ICON_LO])
         dom_pkg::ICON_ERRTRIG: iconBit = pinSync[0];
         dom_pkg::ICON_CSEL:    iconBit = pinSync[1];
         dom_pkg::ICON_SDI:     iconBit = pinSync[2];
         dom_pkg::ICON_SCLK:    iconBit = pinSync[3];
         default:               iconBit = 1'b0;
      endcase
   end

   // ****************************************
   // Output stage
   // ****************************************
   // Everything registered, so a reselect never shows a transient source
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         diagOutputPin <= 1'b0;
         diagOutputOe  <= 1'b0;
         analogSelect  <= 8'h00;
         analogActive  <= 1'b0;
      end else begin
         diagOutputOe <= cfg.enable && (cfg.mode != 2'(dom_pkg::MODE_ANALOG));
         analogActive <= cfg.enable && (cfg.mode == 2'(dom_pkg::MODE_ANALOG));
         analogSelect <= (cfg.enable && cfg.mode == 2'(dom_pkg::MODE_ANALOG))
                         ? cfg.sel : 8'h00;
         unique case (cfg.mode)
            dom_pkg::MODE_FORCED:  diagOutputPin <= cfg.level;
            dom_pkg::MODE_DIGITAL: diagOutputPin <= digBit;
            dom_pkg::MODE_ICON:    diagOutputPin <= iconBit;
            dom_pkg::MODE_ANALOG:  diagOutputPin <= 1'b0;
         endcase
      end
   end

   // Serial out check; the far side must hold select high
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         serialOutForce      <= 1'b0;
         serialOutValue      <= 1'b0;
         serialOutKeepDriven <= 1'b0;
      end else begin
         serialOutForce <= cfg.enable && cfg.mode == 2'(dom_pkg::MODE_DIGITAL)
                           && pinSync[1];
         serialOutValue <= diagConfigReg[dom_pkg::CFG_SOUT_BIT];
         serialOutKeepDriven <= cfg.enable;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_tristate;
      @(posedge core_clk) disable iff (!rst_n)
      !cfg.enable |=> !diagOutputOe;
   endproperty
   a_tristate: assert property (p_tristate) else $error("pin driven while disabled");

   property p_forced;
      @(posedge core_clk) disable iff (!rst_n)
      (cfg.enable && cfg.mode == 2'b00) |=> (diagOutputPin == $past(cfg.level));
   endproperty
   a_forced: assert property (p_forced) else $error("forced level wrong");

   property p_chan0;
      @(posedge core_clk) disable iff (!rst_n)
      (cfg.mode == 2'b01 && chn == 4'h0) |=> !diagOutputPin;
   endproperty
   a_chan0: assert property (p_chan0) else $error("channel zero not low");

   property p_analog;
      @(posedge core_clk) disable iff (!rst_n)
      (cfg.enable && cfg.mode == 2'b10) |=> analogActive && analogSelect == $past(cfg.sel);
   endproperty
   a_analog: assert property (p_analog) else $error("analog select wrong");

   property p_keep;
      @(posedge core_clk) disable iff (!rst_n)
      cfg.enable |=> serialOutKeepDriven;
   endproperty
   a_keep: assert property (p_keep) else $error("serial out released");

   property p_sout;
      @(posedge core_clk) disable iff (!rst_n)
      serialOutForce |-> serialOutValue == $past(diagConfigReg[6]);
   endproperty
   a_sout: assert property (p_sout) else $error("serial out value wrong");

   property p_factory;
      @(posedge core_clk) disable iff (!rst_n)
      (cfg.mode == 2'b01 && cfg.sel[6:0] == 7'h71) |=> diagOutputPin == $past(factoryTestFlag);
   endproperty
   a_factory: assert property (p_factory) else $error("factory flag not routed");

   property p_update;
      @(posedge core_clk) disable iff (!rst_n)
      cfgWe |=> diagSelectField == $past(diagSelectIn);
   endproperty
   a_update: assert property (p_update) else $error("selection not updated");

   property p_errtrig;
      @(posedge core_clk) disable iff (!rst_n)
      (cfg.mode == 2'b01 && cfg.sel[6:0] == 7'h1e) |=> diagOutputPin == $past(pinSync[0]);
   endproperty
   a_errtrig: assert property (p_errtrig) else $error("trigger readback wrong");

   property p_icon;
      @(posedge core_clk) disable iff (!rst_n)
      (cfg.mode == 2'b11 && diagConfigReg[2:0] == 3'h3) |=> diagOutputPin == $past(pinSync[3]);
   endproperty
   a_icon: assert property (p_icon) else $error("interconnect pin wrong");

   property p_sensor_rsv;
      @(posedge core_clk) disable iff (!rst_n)
      (cfg.mode == 2'b01 && cfg.sel[6:4] == 3'h3 && chn > 4'h8) |=> !diagOutputPin;
   endproperty
   a_sensor_rsv: assert property (p_sensor_rsv) else $error("reserved channel not low");
endmodule : dom_diag_mux

//--- core/dom_sync.sv
// Two-flop synchroniser bank for pin and foreign-domain inputs
`timescale 1ns/100ps
module dom_sync #(
   parameter int unsigned W = 8
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule : dom_sync

//--- shared/dom_cfg_if.sv
// Interface carrying registered configuration to the output stage
`timescale 1ns/100ps
interface dom_cfg_if;
   logic       enable;
   logic [1:0] mode;
   logic [7:0] sel;
   logic       level;
   modport src (output enable, output mode, output sel, output level);
   modport dst (input enable, input mode, input sel, input level);
endinterface : dom_cfg_if

//--- shared/dom_pkg.sv
// Package for the diagnostic output multiplexer: fields, codes, reset values
package dom_pkg;
   // ****************************************
   // Configuration fields
   // ****************************************
   localparam int unsigned SEL_W        = 8;
   localparam int unsigned GRP_HI       = 6;
   localparam int unsigned GRP_LO       = 4;
   localparam int unsigned CHN_HI       = 3;
   localparam int unsigned CHN_LO       = 0;
   localparam int unsigned CFG_EN_BIT   = 7;
   localparam int unsigned CFG_SOUT_BIT = 6;
   localparam int unsigned MODE_HI      = 5;
   localparam int unsigned MODE_LO      = 4;
   localparam int unsigned LVL_BIT      = 3;
   localparam int unsigned ICON_HI      = 2;
   localparam int unsigned ICON_LO      = 0;
   localparam logic [7:0]  SEL_RST      = 8'h00;
   localparam logic [7:0]  CFG_RST      = 8'h00;
   localparam logic [7:0]  AN_SEL_MONBG = 8'h80;

   // ****************************************
   // Modes and groups
   // ****************************************
   typedef enum logic [1:0] {
      MODE_FORCED  = 2'b00,
      MODE_DIGITAL = 2'b01,
      MODE_ANALOG  = 2'b10,
      MODE_ICON    = 2'b11
   } dom_mode_e;

   localparam logic [2:0] GRP_SUPPLY = 3'h0;
   localparam logic [2:0] GRP_TIMING = 3'h1;
   localparam logic [2:0] GRP_POWER  = 3'h2;
   localparam logic [2:0] GRP_SENSOR = 3'h3;
   localparam logic [2:0] GRP_FACTORY = 3'h7;

   localparam logic [2:0] ICON_ERRTRIG = 3'h0;
   localparam logic [2:0] ICON_CSEL    = 3'h1;
   localparam logic [2:0] ICON_SDI     = 3'h2;
   localparam logic [2:0] ICON_SCLK    = 3'h3;

   // Group 001 channels that read back pins
   localparam logic [3:0] CHN_ERRTRIG_A   = 4'h9;
   localparam logic [3:0] CHN_CSEL        = 4'ha;
   localparam logic [3:0] CHN_SDI         = 4'hb;
   localparam logic [3:0] CHN_SCLK        = 4'hc;
   localparam logic [3:0] CHN_ERRTRIG_B   = 4'he;
   // Last live channel of group 011; the rest are reserved
   localparam logic [3:0] CHN_SENSOR_LAST = 4'h8;
endpackage : dom_pkg

//--- verif/diagnostic_output_mux_test.sv
// Self-checking bench for the diagnostic output multiplexer
`timescale 1ns/100ps
`define CHK(nm, e, g) \
   begin \
      checks_done++; \
      if ((g) !== (e)) begin \
         mismatches++; \
         $display("Error %s expected %h seen %h", nm, e, g); \
      end \
   end
module diagnostic_output_mux_test;
   // ****************************************
   // Signals
   // ****************************************
   logic        core_clk, rst_n, cfgWe, factoryTestFlag;
   logic [7:0]  diagConfigIn, diagSelectIn, analogSelect, diagConfigReg, diagSelectField, s;
   logic [15:0] grpSupply, grpTiming, grpPower, grpSensor;
   logic [3:0]  pinVec;
   wire logic   errorTriggerPin, chipSelectPin, serialInPin, serialClkPin;
   logic        diagOutputPin, diagOutputOe, analogActive, seenLevel, seenDriven;
   logic        serialOutForce, serialOutValue, serialOutKeepDriven;
   int          mismatches, checks_done;
   integer      seed;

   assign {serialClkPin, serialInPin, chipSelectPin, errorTriggerPin} = pinVec;

   dom_diag_mux dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .cfgWe(cfgWe), .diagConfigIn(diagConfigIn),
      .diagSelectIn(diagSelectIn), .grpSupply(grpSupply), .grpTiming(grpTiming),
      .grpPower(grpPower), .grpSensor(grpSensor), .factoryTestFlag(factoryTestFlag),
      .errorTriggerPin(errorTriggerPin), .chipSelectPin(chipSelectPin),
      .serialInPin(serialInPin), .serialClkPin(serialClkPin), .diagOutputPin(diagOutputPin),
      .diagOutputOe(diagOutputOe), .analogSelect(analogSelect), .analogActive(analogActive),
      .serialOutForce(serialOutForce), .serialOutValue(serialOutValue),
      .serialOutKeepDriven(serialOutKeepDriven), .diagConfigReg(diagConfigReg),
      .diagSelectField(diagSelectField));

   dom_mcu_model host_u (.core_clk(core_clk), .pinLevel(diagOutputPin), .pinOe(diagOutputOe),
      .seenLevel(seenLevel), .seenDriven(seenDriven));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] cfg(input logic en, input logic so, input logic [1:0] md,
                                      input logic lv, input logic [2:0] ic);
      return {en, so, md, lv, ic};
   endfunction : cfg

   // Keeps away from channels whose content is left to production test
   function automatic logic [7:0] legal(input logic [7:0] v);
      logic [3:0] c;
      c = v[3:0];
      case (v[6:4])
         3'h1: if (c == 4'h2) c = 4'h3;
         3'h2: if (c == 4'h1 || c == 4'h2 || c == 4'h8) c = 4'h3;
         3'h7: c = {3'h0, c[0]};
         default: ;
      endcase
      return {1'b0, v[6:4], c};
   endfunction : legal

   function automatic logic exp_dig(input logic [7:0] v);
      logic [3:0] c;
      c = v[3:0];
      if (c == 4'h0) return 1'b0;
      case (v[6:4])
         3'h0: return grpSupply[c];
         3'h1: begin
            case (c)
               4'h9, 4'he: return errorTriggerPin;
               4'ha: return chipSelectPin;
               4'hb: return serialInPin;
               4'hc: return serialClkPin;
               default: return grpTiming[c];
            endcase
         end
         3'h2: return grpPower[c];
         3'h3: return (c > 4'h8) ? 1'b0 : grpSensor[c];
         3'h7: return factoryTestFlag;
         default: return 1'b0;
      endcase
   endfunction : exp_dig

   // Write taken on the next rising edge; wait covers register, output and pin sync
   task automatic wr(input logic [7:0] c, input logic [7:0] v);
      cfgWe = 1'b1;
      diagConfigIn = c;
      diagSelectIn = v;
      @(negedge core_clk);
      cfgWe = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask : wr

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   // ****************************************
   // Stimulus
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   initial begin
      #400000;
      mismatches++;
      close_out();
   end

   initial begin
      seed = 32'h4b08_abf8;
      {rst_n, cfgWe, factoryTestFlag, pinVec, diagConfigIn, diagSelectIn} = '0;
      {grpSupply, grpTiming, grpPower, grpSensor} = '0;
      repeat (10) @(negedge core_clk);
      `CHK("oe in reset", 1'b0, diagOutputOe)
      rst_n = 1'b1;
      @(negedge core_clk);
      `CHK("config reset", dom_pkg::CFG_RST, diagConfigReg)
      `CHK("select reset", dom_pkg::SEL_RST, diagSelectField)
      for (int i = 0; i < 2; i++) begin
         wr(cfg(1'b1, 1'b0, dom_pkg::MODE_FORCED, i[0], 3'h0), 8'h00);
         `CHK("forced pin", i[0], seenLevel)
         `CHK("forced oe", 1'b1, seenDriven)
      end
      wr(cfg(1'b0, 1'b1, dom_pkg::MODE_FORCED, 1'b1, 3'h0), 8'h00);
      `CHK("disabled oe", 1'b0, seenDriven)
      `CHK("keep driven off", 1'b0, serialOutKeepDriven)
      for (int i = 7; i >= 0; i--) begin
         wr(cfg(1'b1, 1'b0, dom_pkg::MODE_ANALOG, 1'b0, 3'h0), 8'h01 << i);
         if (i == 7) `CHK("bandgap code", dom_pkg::AN_SEL_MONBG, analogSelect)
         `CHK("analog select", 8'h01 << i, analogSelect)
         `CHK("analog active", 1'b1, analogActive)
         `CHK("analog oe", 1'b0, seenDriven)
      end
      for (int i = 0; i < 8; i++) begin
         pinVec = 4'($random(seed));
         wr(cfg(1'b1, 1'b0, dom_pkg::MODE_ICON, 1'b0, i[2:0]), 8'h00);
         `CHK("interconnect pin", (i < 4) ? pinVec[i] : 1'b0, seenLevel)
      end
      for (int n = 0; n < 40; n++) begin
         {grpSupply, grpTiming} = 32'($random(seed));
         {grpPower, grpSensor} = 32'($random(seed));
         {factoryTestFlag, pinVec} = 5'($random(seed));
         s = (n < 6) ? legal(8'({n[2:0], 4'h0}) ^ 8'h5e) : legal(8'($random(seed)));
         if (n == 0) s = 8'h3f;
         wr(cfg(1'b1, 1'b0, dom_pkg::MODE_DIGITAL, 1'b0, 3'h0), s);
         `CHK("select readback", s, diagSelectField)
         `CHK("digital oe", 1'b1, seenDriven)
         `CHK("digital pin", exp_dig(s), seenLevel)
      end
      pinVec = 4'h2;
      wr(cfg(1'b1, 1'b1, dom_pkg::MODE_DIGITAL, 1'b0, 3'h0), 8'h00);
      `CHK("serial force", 1'b1, serialOutForce)
      `CHK("serial value", 1'b1, serialOutValue)
      `CHK("pin low in check", 1'b0, seenLevel)
      `CHK("keep driven", 1'b1, serialOutKeepDriven)
      pinVec = 4'h0;
      repeat (4) @(negedge core_clk);
      `CHK("serial force off", 1'b0, serialOutForce)
      cfgWe = 1'b1;
      diagConfigIn = cfg(1'b1, 1'b0, dom_pkg::MODE_FORCED, 1'b1, 3'h0);
      @(negedge core_clk);
      diagConfigIn = cfg(1'b1, 1'b0, dom_pkg::MODE_FORCED, 1'b0, 3'h0);
      @(negedge core_clk);
      cfgWe = 1'b0;
      `CHK("back to back first", 1'b1, seenLevel)
      repeat (2) @(negedge core_clk);
      `CHK("back to back", 8'h80, diagConfigReg)
      `CHK("back to back pin", 1'b0, seenLevel)
      close_out();
   end
endmodule : diagnostic_output_mux_test

//--- verif/dom_mcu_model.sv
// Host input stage model reading the diagnostic pin
`timescale 1ns/100ps
module dom_mcu_model (
   // Clock
   input  wire logic core_clk,
   // Pin as driven by the device
   input  wire logic pinLevel,
   input  wire logic pinOe,
   // What the host input stage sees
   output logic      seenLevel,
   output logic      seenDriven
);
   logic lastLevel_r;

   // No pull on this net: a released pin shows the inverse of its last level,
   // so a stale value can never pass for a driven one
   always_ff @(posedge core_clk) begin
      if (pinOe) begin
         lastLevel_r <= pinLevel;
      end
   end
   assign seenDriven = pinOe;
   assign seenLevel  = pinOe ? pinLevel : ~lastLevel_r;
endmodule : dom_mcu_model
